// ===== fasg_bus_cycle.sv
`timescale 1ns/1ns
module fasg_bus_cycle (
	input  wire logic                      core_clk,
	input  wire logic                      resetn,
	input  wire logic                      start,
	input  wire logic                      isWrite,
	input  wire logic [fasg_pkg::ADDR_W-1:0] addr,
	input  wire logic [fasg_pkg::DATA_W-1:0] wdata,
	input  wire logic                      hvAddrNine,
	input  wire logic [fasg_pkg::DATA_W-1:0] dqIn,
	output logic                           busy,
	output logic                           done,
	output logic [fasg_pkg::DATA_W-1:0]    rdata,
	output fasg_pkg::fasg_pins_t           pins
);
	import fasg_pkg::*;

	typedef enum logic [1:0] {
		BC_IDLE   = 2'b00,
		BC_SETUP  = 2'b01,
		BC_STROBE = 2'b10,
		BC_HOLD   = 2'b11
	} fasg_bc_t;

	fasg_bc_t          state_ff;
	logic [3:0]        cnt_ff;
	logic              wr_ff;
	fasg_pins_t        pins_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic              done_ff;

	function automatic logic [3:0] strobeLen(input logic w);
		strobeLen = w ? 4'(WE_LOW_CYC) : 4'(READ_CYC);
	endfunction : strobeLen

	assign busy  = (state_ff != BC_IDLE);
	assign done  = done_ff;
	assign rdata = rdata_ff;
	assign pins  = pins_ff;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= BC_IDLE;
			cnt_ff   <= 4'h0;
			wr_ff    <= 1'b0;
			done_ff  <= 1'b0;
			pins_ff  <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: '0,
				dqOut: '0, dqOe: 1'b0, hvAddrNine: 1'b0};
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				BC_IDLE: begin
					if (start) begin
						// address settles before any strobe falls
						pins_ff.addr       <= addr;
						pins_ff.hvAddrNine <= hvAddrNine;
						pins_ff.dqOut      <= wdata;
						pins_ff.dqOe       <= isWrite;
						wr_ff              <= isWrite;
						state_ff           <= BC_SETUP;
					end
				end
				BC_SETUP: begin
					// write: both enables low, output enable high
					pins_ff.ceN <= 1'b0;
					pins_ff.oeN <= wr_ff;
					pins_ff.weN <= !wr_ff;
					cnt_ff      <= strobeLen(wr_ff);
					state_ff    <= BC_STROBE;
				end
				BC_STROBE: begin
					// strobe held a full cycle, far above glitch width
					if (cnt_ff <= 4'h1) begin
						// write-enable rises first: data latched here
						pins_ff.weN <= 1'b1;
						pins_ff.oeN <= 1'b1;
						state_ff    <= BC_HOLD;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				BC_HOLD: begin
					pins_ff.ceN  <= 1'b1;
					pins_ff.dqOe <= 1'b0;
					pins_ff.hvAddrNine <= 1'b0;
					done_ff      <= 1'b1;
					state_ff     <= BC_IDLE;
				end
				default: state_ff <= BC_IDLE;
			endcase
		end
	end

	// read data sampled while output enable still low
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= '0;
		end else if (state_ff == BC_STROBE && cnt_ff <= 4'h1 && !wr_ff) begin
			rdata_ff <= dqIn;
		end
	end

endmodule : fasg_bus_cycle

// ===== fasg_flash_model.sv
`timescale 1ns/1ns
module fasg_flash_model #(
	parameter logic [7:0] MAKER = 8'h3C, // arbitrary value
	parameter logic [7:0] PART  = 8'hA7  // arbitrary value
) (
	input  fasg_pkg::fasg_pins_t               pins,
	input  wire logic                          supplyOk,
	input  wire logic [7:0]                    protMask,
	output logic      [fasg_pkg::DATA_W-1:0]   dqIn
);
	import fasg_pkg::*;
	logic [1:0]        step = 2'h0;
	logic              idMode = 1'b0;
	logic [ADDR_W-1:0] la;
	logic [DATA_W-1:0] last = 16'h0000;
	time               tFall = 0;
	logic              armed = 1'b0;
	wire wrN = pins.ceN | pins.weN | ~pins.oeN;
	wire rd = !pins.ceN && !pins.oeN;
	wire [7:0] d = pins.dqOut[7:0];
	wire idr = (pins.hvAddrNine && !pins.addr[6]) || idMode;
	wire [1:0] it = pins.addr[1:0];
	wire [7:0] pick = it == 2'h0 ? MAKER : it == 2'h1 ? PART :
		{7'h00, protMask[pins.addr[SECT_LSB+:3]]};
	wire [DATA_W-1:0] val = idr ? {8'h00, pick} : pins.addr[15:0] ^ 16'h5A5A;
	assign dqIn = rd ? val : ~last; // released bus drives the inverse of the last read word
	always @(negedge rd) last = val;
	always @(negedge wrN) begin
		la = pins.addr;
		tFall = $time;
		armed = 1'b1;
	end
	always @(negedge supplyOk) begin
		step = 2'h0;
		idMode = 1'b0;
		armed = 1'b0;
	end
	// a rising edge with no falling edge before it is a power-up edge
	always @(posedge wrN)
		if (armed && supplyOk && $time - tFall >= 5) begin
		case (step)
			2'h0: begin
				step = (la == UNLOCK_ADDR1 && d == UNLOCK_DATA1) ? 2'h1 : 2'h0;
				if (d == RESET_CMD) idMode = 1'b0;
			end
			2'h1: step = (la == UNLOCK_ADDR2 && d == UNLOCK_DATA2) ? 2'h2 : 2'h0;
			default: begin
				idMode = la == UNLOCK_ADDR1 && d == IDENT_CMD;
				step = 2'h0;
			end
		endcase
	end
endmodule : fasg_flash_model

// ===== fasg_host.sv
`timescale 1ns/1ns
// Contract
// - high-voltage read: A6 low, A1/A0 pick maker, part, protection
// - protection read puts sector address on upper address bits
// - protect all unprotected sectors before first unprotect write (host does not enforce this)
// - write needs chip and write enable low, output enable high
// - host writes reset command to leave identification mode
module fasg_host (
	input  wire logic                        core_clk,
	input  wire logic                        resetn,
	input  wire logic                        reqValid,
	output logic                             reqReady,
	input  fasg_pkg::fasg_req_t              req,
	output logic                             rspValid,
	output logic [7:0]                       rspData,
	output logic                             idModeOn,
	input  wire logic                        supplyOk,
	input  wire logic [fasg_pkg::DATA_W-1:0] dqIn,
	output fasg_pkg::fasg_pins_t             pins
);
	import fasg_pkg::*;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_UNL1 = 3'b001,
		HS_UNL2 = 3'b010,
		HS_CMD  = 3'b011,
		HS_XFER = 3'b100,
		HS_WAIT = 3'b101
	} fasg_hs_t;

	fasg_hs_t          state_ff;
	fasg_req_t         cur_ff;
	logic              idMode_ff;
	logic              rspValid_ff;
	logic [7:0]        rspData_ff;
	logic              bcStart;
	logic              bcWrite;
	logic [ADDR_W-1:0] bcAddr;
	logic [DATA_W-1:0] bcData;
	logic              bcHv;
	logic              bcBusy;
	logic              bcDone;
	logic [DATA_W-1:0] bcRdata;

	// identification address: item in low bits, sector above
	function automatic logic [ADDR_W-1:0] idAddr(input fasg_req_t r,
			input logic hv);
		logic [ADDR_W-1:0] a;
		a = {r.addr[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
		if (hv) begin
			a[BIT_A6] = 1'b0;
			a[BIT_A1] = (r.item == IDX_PROTECT);
			a[BIT_A0] = (r.item == IDX_PART);
		end else begin
			a[1:0] = r.item;
		end
		idAddr = a;
	endfunction : idAddr

	// new requests are refused below the lockout threshold; a started unlock sequence still writes
	assign reqReady = (state_ff == HS_IDLE) && supplyOk;
	assign rspValid = rspValid_ff;
	assign rspData  = rspData_ff;
	assign idModeOn = idMode_ff;

	always_comb begin
		bcStart = 1'b0;
		bcWrite = 1'b1;
		bcAddr  = cur_ff.addr;
		bcData  = cur_ff.data;
		bcHv    = 1'b0;
		case (state_ff)
			// hold off in the done cycle, else the word is sent twice
			HS_UNL1: begin
				bcStart = !bcBusy && !bcDone;
				bcAddr  = UNLOCK_ADDR1;
				bcData  = {8'h00, UNLOCK_DATA1};
			end
			HS_UNL2: begin
				bcStart = !bcBusy && !bcDone;
				bcAddr  = UNLOCK_ADDR2;
				bcData  = {8'h00, UNLOCK_DATA2};
			end
			HS_CMD: begin
				bcStart = !bcBusy && !bcDone;
				bcAddr  = UNLOCK_ADDR1;
				bcData  = {8'h00, IDENT_CMD};
			end
			HS_XFER: begin
				bcStart = !bcBusy;
				case (cur_ff.op)
					OP_ID_READ: begin
						bcWrite = 1'b0;
						bcAddr  = idAddr(cur_ff, 1'b0);
					end
					OP_HV_READ: begin
						bcWrite = 1'b0;
						bcHv    = 1'b1;
						bcAddr  = idAddr(cur_ff, 1'b1);
					end
					OP_ID_EXIT: begin
						bcData = {8'h00, RESET_CMD};
					end
					OP_READ: bcWrite = 1'b0;
					default: bcWrite = 1'b1;
				endcase
			end
			default: bcStart = 1'b0;
		endcase
	end

	// protect and unprotect writes go out as plain OP_WRITE, with no
	// sequencing; mode tracking assumes bad sequences already abort
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= HS_IDLE;
			cur_ff   <= '0;
		end else begin
			case (state_ff)
				HS_IDLE: begin
					if (reqValid && supplyOk && req.op != OP_NONE) begin
						cur_ff   <= req;
						state_ff <= (req.op == OP_ID_ENTER) ? HS_UNL1 : HS_XFER;
					end
				end
				HS_UNL1: if (bcDone) state_ff <= HS_UNL2;
				HS_UNL2: if (bcDone) state_ff <= HS_CMD;
				HS_CMD:  if (bcDone) state_ff <= HS_IDLE;
				HS_XFER: if (bcStart) state_ff <= HS_WAIT;
				HS_WAIT: if (bcDone) state_ff <= HS_IDLE;
				default: state_ff <= HS_IDLE;
			endcase
		end
	end

	// supply loss resets the device, so its mode is forgotten
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			idMode_ff <= 1'b0;
		end else if (!supplyOk) begin
			idMode_ff <= 1'b0;
		end else if (state_ff == HS_CMD && bcDone) begin
			idMode_ff <= 1'b1;
		end else if (state_ff == HS_WAIT && bcDone
				&& cur_ff.op == OP_ID_EXIT) begin
			idMode_ff <= 1'b0;
		end
	end

	// only the low data byte carries identification
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rspValid_ff <= 1'b0;
			rspData_ff  <= 8'h00;
		end else begin
			rspValid_ff <= (state_ff == HS_WAIT) && bcDone;
			if (state_ff == HS_WAIT && bcDone) begin
				rspData_ff <= bcRdata[7:0];
			end
		end
	end

	fasg_bus_cycle u_cycle (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.start      (bcStart),
		.isWrite    (bcWrite),
		.addr       (bcAddr),
		.wdata      (bcData),
		.hvAddrNine (bcHv),
		.dqIn       (dqIn),
		.busy       (bcBusy),
		.done       (bcDone),
		.rdata      (bcRdata),
		.pins       (pins)
	);

endmodule : fasg_host

// ===== fasg_host_chk.sv
`timescale 1ns/1ns
module fasg_host_chk (
	input  wire logic            core_clk,
	input  wire logic            resetn,
	input  wire logic            reqValid,
	input  wire logic            reqReady,
	input  fasg_pkg::fasg_req_t  req,
	input  wire logic            rspValid,
	input  wire logic            idModeOn,
	input  wire logic            supplyOk,
	input  fasg_pkg::fasg_pins_t pins
);
	import fasg_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire tk = reqValid && reqReady;
	wire rdOp = req.op inside {OP_ID_READ, OP_HV_READ, OP_READ};
	sequence s_wpulse;
		!pins.weN ##1 pins.weN;
	endsequence
	a_lockout_ready: assert property (!supplyOk |-> !reqReady)
		else $error("ready while supply low");
	a_lockout_idmode: assert property (!supplyOk |-> ##[0:2] !idModeOn)
		else $error("id mode kept under lockout");
	a_write_enables: assert property (!pins.weN |-> !pins.ceN && pins.oeN)
		else $error("write strobe without chip enable");
	a_read_nodrive: assert property (!pins.oeN |-> !pins.dqOe)
		else $error("data driven during read");
	a_we_pulse: assert property ($fell(pins.weN) |-> s_wpulse)
		else $error("write strobe width wrong");
	a_strobe_stable: assert property (!pins.weN |->
		$stable(pins.addr) && $stable(pins.dqOut))
		else $error("address or data moved in strobe");
	a_hv_select: assert property (pins.hvAddrNine |-> !pins.addr[BIT_A6])
		else $error("a6 high in high-voltage read");
	a_id_enter: assert property (tk && req.op == OP_ID_ENTER |->
		##[1:30] idModeOn)
		else $error("id mode not entered");
	a_id_exit: assert property (tk && req.op == OP_ID_EXIT |->
		##[1:12] !idModeOn)
		else $error("id mode not left");
	a_read_answer: assert property (tk && rdOp |-> ##[3:10] rspValid)
		else $error("read not answered");
endmodule : fasg_host_chk
bind fasg_host fasg_host_chk u_chk (.core_clk(core_clk), .resetn(resetn),
	.reqValid(reqValid), .reqReady(reqReady), .req(req),
	.rspValid(rspValid), .idModeOn(idModeOn), .supplyOk(supplyOk),
	.pins(pins));

// ===== fasg_pkg.sv
package fasg_pkg;

	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;

	// command-interface unlock and command words
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 19'h0_0555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 19'h0_02AA;
	localparam logic [7:0]        UNLOCK_DATA1 = 8'hAA;
	localparam logic [7:0]        UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0]        IDENT_CMD    = 8'h90;
	localparam logic [7:0]        RESET_CMD    = 8'hF0;

	// identification word offsets
	localparam logic [1:0] IDX_MAKER   = 2'h0;
	localparam logic [1:0] IDX_PART    = 2'h1;
	localparam logic [1:0] IDX_PROTECT = 2'h2;
	localparam int         SECT_LSB    = 12;

	// high-voltage method address bits
	localparam int BIT_A0 = 0;
	localparam int BIT_A1 = 1;
	localparam int BIT_A6 = 6;

	// bus timing, 25 MHz core clock
	localparam int CLK_NS      = 40;
	localparam int WE_LOW_NS   = 35;
	localparam int SETUP_NS    = 0;
	localparam int READ_ACC_NS = 70;
	localparam int WE_LOW_CYC  = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_CYC    = (READ_ACC_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [2:0] {
		OP_NONE      = 3'b000,
		OP_ID_ENTER  = 3'b001,
		OP_ID_READ   = 3'b010,
		OP_ID_EXIT   = 3'b011,
		OP_HV_READ   = 3'b100,
		OP_WRITE     = 3'b101,
		OP_READ      = 3'b110
	} fasg_op_t;

	typedef struct packed {
		fasg_op_t          op;
		logic [1:0]        item;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fasg_req_t;

	typedef struct packed {
		logic              ceN;
		logic              oeN;
		logic              weN;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dqOut;
		logic              dqOe;
		logic              hvAddrNine;
	} fasg_pins_t;

endpackage : fasg_pkg

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import fasg_pkg::*;
	localparam logic [7:0] MK = 8'h3C; // arbitrary value
	localparam logic [7:0] PT = 8'hA7; // arbitrary value
	logic              core_clk = 0, resetn = 0, reqValid = 0, supplyOk = 1;
	logic              reqReady, rspValid, idModeOn;
	logic [7:0]        rspData;
	logic [7:0]        protMask = 8'h00;
	logic [DATA_W-1:0] dqIn;
	fasg_req_t         req = '0;
	fasg_pins_t        pins;
	int                errors = 0, checked = 0, cyc = 0;
	always #20 core_clk = ~core_clk;
	fasg_host u_fasg_host (.core_clk(core_clk), .resetn(resetn),
		.reqValid(reqValid), .reqReady(reqReady), .req(req),
		.rspValid(rspValid), .rspData(rspData), .idModeOn(idModeOn),
		.supplyOk(supplyOk), .dqIn(dqIn), .pins(pins));
	fasg_flash_model #(.MAKER(MK), .PART(PT)) u_fasg_flash_model (
		.pins(pins), .supplyOk(supplyOk), .protMask(protMask), .dqIn(dqIn));
	task automatic complete_run;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [7:0] idv(input int it, input logic [18:0] a);
		return it == 0 ? MK : it == 1 ? PT : {7'h00, protMask[a[14:12]]};
	endfunction : idv
	// waits are bounded so a stuck handshake ends in the timeout report
	task automatic run(input fasg_op_t op, input int it,
		input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge core_clk);
		while (!reqReady && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		req = '{op, it[1:0], a, {8'h00, d}};
		reqValid = 1;
		@(negedge core_clk);
		reqValid = 0;
		while (!(op inside {OP_ID_READ, OP_HV_READ, OP_READ} ? rspValid
			: reqReady) && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 100) begin
			errors++;
			$display("ERROR %0t: handshake timeout", $time);
		end
	endtask : run
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			$display("ERROR %0t: timeout", $time);
			complete_run;
		end
	end
	initial begin
		logic [ADDR_W-1:0] a;
		void'($urandom(75683));
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1;
		for (int k = 0; k < 8; k++) begin
			a = $urandom;
			run(OP_READ, 0, a, 8'h00);
			chk(rspData, a[7:0] ^ 8'h5A);
		end
		$display("array read done");
		for (int k = 0; k < 6; k++) begin
			if (k == 3) protMask = $urandom;
			a = $urandom;
			run(OP_HV_READ, k % 3, a, 8'h00);
			chk(rspData, idv(k % 3, a));
		end
		$display("high-voltage identification done");
		run(OP_ID_ENTER, 0, 19'h0_0000, 8'h00);
		chk({7'h00, idModeOn}, 8'h01);
		for (int k = 0; k < 6; k++) begin
			a = $urandom;
			run(OP_ID_READ, k % 3, a, 8'h00);
			chk(rspData, idv(k % 3, a));
		end
		run(OP_ID_EXIT, 0, 19'h0_0000, RESET_CMD);
		chk({7'h00, idModeOn}, 8'h00);
		run(OP_READ, 0, a, 8'h00);
		chk(rspData, a[7:0] ^ 8'h5A);
		$display("command identification done");
		run(OP_WRITE, 0, UNLOCK_ADDR1, UNLOCK_DATA1);
		run(OP_WRITE, 0, UNLOCK_ADDR2, 8'h11);
		run(OP_WRITE, 0, UNLOCK_ADDR1, IDENT_CMD);
		run(OP_READ, 0, 19'h0_0003, 8'h00);
		chk(rspData, 8'h03 ^ 8'h5A);
		chk({7'h00, idModeOn}, 8'h00);
		$display("abort done");
		run(OP_ID_ENTER, 0, 19'h0_0000, 8'h00);
		supplyOk = 0;
		repeat (3) @(negedge core_clk);
		chk({7'h00, idModeOn}, 8'h00);
		chk({7'h00, reqReady}, 8'h00);
		supplyOk = 1;
		run(OP_READ, 0, 19'h0_0000, 8'h00);
		chk(rspData, 8'h5A);
		$display("lockout done");
		complete_run;
	end
endmodule : tb_top
